/* File: src/fde_cfg.svh */
// Constants of the fieldbus datagram executor: commands, header layout, memory map.
`ifndef FDE_CFG_SVH
`define FDE_CFG_SVH
`define FDE_CMD_NOP 8'h00
`define FDE_CMD_POS_RD 8'h01
`define FDE_CMD_POS_WR 8'h02
`define FDE_CMD_POS_RW 8'h03
`define FDE_CMD_NODE_RD 8'h04
`define FDE_CMD_NODE_WR 8'h05
`define FDE_CMD_NODE_RW 8'h06
`define FDE_CMD_BC_RD 8'h07
`define FDE_CMD_BC_WR 8'h08
`define FDE_CMD_BC_RW 8'h09
`define FDE_CMD_LOG_RD 8'h0A
`define FDE_CMD_LOG_WR 8'h0B
`define FDE_CMD_LOG_RW 8'h0C
`define FDE_CMD_POS_RMW 8'h0D
`define FDE_CMD_NODE_RMW 8'h0E
`define FDE_HDR_IDX 4'h1
`define FDE_HDR_ADDR0 4'h2
`define FDE_HDR_ADDR1 4'h3
`define FDE_HDR_ADDR2 4'h4
`define FDE_HDR_ADDR3 4'h5
`define FDE_HDR_LEN0 4'h6
`define FDE_HDR_LEN1 4'h7
`define FDE_HDR_LAST 4'h9
`define FDE_MORE_BIT 7
`define FDE_PM_BASE 16'h1000
`define FDE_REG_BYTES 16'h0100
`define FDE_PM_BYTES 16'h0100
`define FDE_MEM_AW 9
`define FDE_STATION_OFS 16'h0010
`define FDE_ALIAS_EN_OFS 16'h0012
`endif

/* File: src/fde_pkg.sv */
// Types shared by the fieldbus datagram executor.
`default_nettype none
package fde_pkg;
  typedef struct packed {
    logic sof;
    logic [7:0] data;
  } fde_byte_type;
  typedef struct packed {
    logic enable;
    logic rd_en;
    logic wr_en;
    logic [31:0] log_start;
    logic [15:0] log_len;
    logic [15:0] phys_start;
    logic [2:0] start_bit;
    logic [2:0] stop_bit;
  } fde_lmu_type;
  typedef enum logic [2:0] {F_IDLE, F_HDR, F_DATA, F_WKC0, F_WKC1} fde_field_type;
  typedef enum logic [2:0] {C_NONE, C_POS, C_NODE, C_BC, C_LOG} fde_cls_type;
endpackage : fde_pkg
`default_nettype wire

/* File: src/fde_mem.sv */
// Local byte memory: register space in the low half, process memory in the high half.
`timescale 1ns/1ps
`default_nettype none
`include "fde_cfg.svh"
module fde_mem (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [`FDE_MEM_AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [`FDE_MEM_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data
);
  logic [7:0] mem [0:(1<<`FDE_MEM_AW)-1];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data <= 8'h00;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : fde_mem
`default_nettype wire

/* File: src/fde_executor.sv */
// Fieldbus datagram executor: decodes and executes datagrams on the fly.
//
// Summary of operation
// - Position commands increment position; zero addresses.
// - Node match on station or alias address.
// - Alias compared only when master enabled it.
// - Only datagram writes change station address.
// - Broadcast addresses every device regardless.
// - Offsets below 0x1000 registers, above memory.
// - Logical address translated by mapping unit.
// - Logical read/write need matching enabled direction.
// - Logical read keeps unmapped bits from datagram.
// - Trailing 16-bit working counter updated here.
// - Count only accessible, successful accesses: addressed, or multi-write writes.
// - Increment +1, or +1/+2/+3 for readwrite.
// - Readwrite reads location before writing it.
// - Command byte decode; 15-255 reserved.
// - Broadcast read returns memory OR datagram data.
// - Broadcast commands also increment position field.
// - Multi-write: match reads, others write memory.
// - Multi-write counts as read or write accordingly.
// - Parse 11-bit length; keep index byte.
// - More flag chains datagrams; stop after last.
`timescale 1ns/1ps
`default_nettype none
`include "fde_cfg.svh"
module fde_executor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rx_valid,
  input wire fde_pkg::fde_byte_type rx,
  input wire logic [15:0] alias_addr,
  input wire fde_pkg::fde_lmu_type lmu,
  output logic tx_valid,
  output fde_pkg::fde_byte_type tx,
  output logic [15:0] station_addr,
  output logic alias_en
);
  ////////////////////////////////////////////////////////////////////////////
  fde_pkg::fde_field_type field;
  fde_pkg::fde_cls_type cls;
  logic [3:0] hdr_cnt;
  logic [7:0] cmd;
  logic [7:0] addr_b [0:3];
  logic [10:0] len;
  logic [10:0] dcnt;
  logic more;
  logic pos_zero;
  logic node_hit;
  logic pos_carry;
  logic wkc_carry;
  logic rd_ok;
  logic wr_ok;
  logic s1_valid;
  logic s1_sof;
  logic [7:0] s1_din;
  logic [7:0] s1_byte;
  logic s1_rd;
  logic s1_wr;
  logic [7:0] s1_mask;
  logic s1_bc;
  logic s1_log;
  logic [`FDE_MEM_AW-1:0] s1_idx;
  logic [7:0] rdata;

  logic is_hdr;
  logic [3:0] cur_hdr;
  logic is_rd;
  logic is_wr;
  logic is_rw;
  logic is_rmw;
  logic addressed;
  logic [15:0] dev_ofs;
  logic [31:0] log_addr;
  logic [31:0] log_rel;
  logic lmu_hit;
  logic [15:0] phys;
  logic acc;
  logic [`FDE_MEM_AW-1:0] idx;
  logic [7:0] mask;
  logic do_rd;
  logic do_wr;
  logic [1:0] wkc_inc;
  logic [7:0] next_byte;
  logic [7:0] out_byte;
  logic [7:0] wr_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.
  always_comb
  begin
    unique case (cmd)
      `FDE_CMD_POS_RD, `FDE_CMD_POS_WR, `FDE_CMD_POS_RW, `FDE_CMD_POS_RMW: cls = fde_pkg::C_POS;
      `FDE_CMD_NODE_RD, `FDE_CMD_NODE_WR, `FDE_CMD_NODE_RW, `FDE_CMD_NODE_RMW:
        cls = fde_pkg::C_NODE;
      `FDE_CMD_BC_RD, `FDE_CMD_BC_WR, `FDE_CMD_BC_RW: cls = fde_pkg::C_BC;
      `FDE_CMD_LOG_RD, `FDE_CMD_LOG_WR, `FDE_CMD_LOG_RW: cls = fde_pkg::C_LOG;
      default: cls = fde_pkg::C_NONE;
    endcase
  end

  assign is_rd = cmd inside {`FDE_CMD_POS_RD, `FDE_CMD_NODE_RD, `FDE_CMD_BC_RD, `FDE_CMD_LOG_RD};
  assign is_wr = cmd inside {`FDE_CMD_POS_WR, `FDE_CMD_NODE_WR, `FDE_CMD_BC_WR, `FDE_CMD_LOG_WR};
  assign is_rw = cmd inside {`FDE_CMD_POS_RW, `FDE_CMD_NODE_RW, `FDE_CMD_BC_RW, `FDE_CMD_LOG_RW};
  assign is_rmw = cmd inside {`FDE_CMD_POS_RMW, `FDE_CMD_NODE_RMW};
  assign addressed = (cls == fde_pkg::C_POS) ? pos_zero :
                     (cls == fde_pkg::C_NODE) ? node_hit : (cls == fde_pkg::C_BC);

  ////////////////////////////////////////////////////////////////////////////
  // Address translation for the current data byte.
  assign dev_ofs = {addr_b[3], addr_b[2]} + {5'h00, dcnt};
  assign log_addr = {addr_b[3], addr_b[2], addr_b[1], addr_b[0]} + {21'h00_0000, dcnt};
  assign log_rel = log_addr - lmu.log_start;
  assign lmu_hit = lmu.enable && (log_addr >= lmu.log_start) &&
                   (log_rel < {16'h0000, lmu.log_len});
  assign phys = (cls == fde_pkg::C_LOG) ? lmu.phys_start + log_rel[15:0] : dev_ofs;

  // Addresses beyond the implemented space are inaccessible and never count.
  always_comb
  begin
    if (phys < `FDE_PM_BASE)
    begin
      acc = phys < `FDE_REG_BYTES;
      idx = {1'b0, phys[`FDE_MEM_AW-2:0]};
    end
    else
    begin
      acc = (phys - `FDE_PM_BASE) < `FDE_PM_BYTES;
      idx = {1'b1, phys[`FDE_MEM_AW-2:0]};
    end
  end

  always_comb
  begin
    mask = 8'hFF;
    if (cls == fde_pkg::C_LOG)
    begin
      if (log_rel == 32'h0000_0000)
      begin
        mask = mask & (8'hFF << lmu.start_bit);
      end
      if (log_rel == {16'h0000, lmu.log_len - 16'h0001})
      begin
        mask = mask & (8'hFF >> (3'h7 - lmu.stop_bit));
      end
    end
  end

  always_comb
  begin
    do_rd = 1'b0;
    do_wr = 1'b0;
    if (field == fde_pkg::F_DATA && rx_valid && !rx.sof)
    begin
      if (cls == fde_pkg::C_LOG)
      begin
        do_rd = (is_rd || is_rw) && lmu_hit && lmu.rd_en && acc;
        do_wr = (is_wr || is_rw) && lmu_hit && lmu.wr_en && acc;
      end
      else if (cls != fde_pkg::C_NONE)
      begin
        do_rd = addressed && (is_rd || is_rw || is_rmw) && acc;
        do_wr = ((addressed && (is_wr || is_rw)) || (is_rmw && !addressed)) && acc;
      end
    end
  end

  assign wkc_inc = is_rw ? {wr_ok, rd_ok} : {1'b0, rd_ok || wr_ok};
  assign is_hdr = field == fde_pkg::F_HDR;
  assign cur_hdr = rx.sof ? 4'h0 : hdr_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Header and trailer bytes are rewritten before the memory stage.
  always_comb
  begin
    next_byte = rx.data;
    if ((is_hdr || rx.sof) && (cls == fde_pkg::C_POS || cls == fde_pkg::C_BC))
    begin
      if (cur_hdr == `FDE_HDR_ADDR0)
      begin
        next_byte = rx.data + 8'h01;
      end
      else if (cur_hdr == `FDE_HDR_ADDR1)
      begin
        next_byte = rx.data + {7'h00, pos_carry};
      end
    end
    if (field == fde_pkg::F_WKC0 && !rx.sof)
    begin
      next_byte = rx.data + {6'h00, wkc_inc};
    end
    else if (field == fde_pkg::F_WKC1 && !rx.sof)
    begin
      next_byte = rx.data + {7'h00, wkc_carry};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datagram field sequencing.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      field <= fde_pkg::F_IDLE;
      hdr_cnt <= 4'h0;
      dcnt <= 11'h000;
    end
    else if (rx_valid)
    begin
      if (rx.sof)
      begin
        field <= fde_pkg::F_HDR;
        hdr_cnt <= 4'h1;
      end
      else
      begin
        unique case (field)
          fde_pkg::F_IDLE: field <= fde_pkg::F_IDLE;
          fde_pkg::F_HDR:
          begin
            hdr_cnt <= hdr_cnt + 4'h1;
            dcnt <= 11'h000;
            if (hdr_cnt == `FDE_HDR_LAST)
            begin
              field <= (len == 11'h000) ? fde_pkg::F_WKC0 : fde_pkg::F_DATA;
            end
          end
          fde_pkg::F_DATA:
          begin
            dcnt <= dcnt + 11'h001;
            if (dcnt == len - 11'h001)
            begin
              field <= fde_pkg::F_WKC0;
            end
          end
          fde_pkg::F_WKC0: field <= fde_pkg::F_WKC1;
          fde_pkg::F_WKC1:
          begin
            field <= more ? fde_pkg::F_HDR : fde_pkg::F_IDLE;
            hdr_cnt <= 4'h0;
          end
        endcase
      end
    end
  end

  // Header fields are captured as they pass.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd <= `FDE_CMD_NOP;
      addr_b <= '{8'h00, 8'h00, 8'h00, 8'h00};
      len <= 11'h000;
      more <= 1'b0;
      pos_zero <= 1'b0;
      node_hit <= 1'b0;
      pos_carry <= 1'b0;
    end
    else if (rx_valid && (is_hdr || rx.sof))
    begin
      unique case (cur_hdr)
        4'h0: cmd <= rx.data;
        `FDE_HDR_ADDR0:
        begin
          addr_b[0] <= rx.data;
          pos_carry <= rx.data == 8'hFF;
        end
        `FDE_HDR_ADDR1:
        begin
          addr_b[1] <= rx.data;
          pos_zero <= (addr_b[0] == 8'h00) && (rx.data == 8'h00);
          node_hit <= ({rx.data, addr_b[0]} == station_addr) ||
                      (alias_en && ({rx.data, addr_b[0]} == alias_addr));
        end
        `FDE_HDR_ADDR2: addr_b[2] <= rx.data;
        `FDE_HDR_ADDR3: addr_b[3] <= rx.data;
        `FDE_HDR_LEN0: len[7:0] <= rx.data;
        `FDE_HDR_LEN1:
        begin
          len[10:8] <= rx.data[2:0];
          more <= rx.data[`FDE_MORE_BIT];
        end
        default: cmd <= cmd;
      endcase
    end
  end

  // Access success is collected per datagram and spent on the trailer.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_ok <= 1'b0;
      wr_ok <= 1'b0;
      wkc_carry <= 1'b0;
    end
    else if (rx_valid)
    begin
      if (is_hdr || rx.sof)
      begin
        rd_ok <= 1'b0;
        wr_ok <= 1'b0;
      end
      else
      begin
        rd_ok <= rd_ok || do_rd;
        wr_ok <= wr_ok || do_wr;
      end
      if (field == fde_pkg::F_WKC0)
      begin
        wkc_carry <= ({1'b0, rx.data} + {7'h00, wkc_inc}) > 9'h0FF;
      end
    end
  end

  // Station address and alias enable are only reachable by datagram writes.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      station_addr <= 16'h0000;
      alias_en <= 1'b0;
    end
    else if (do_wr && cls != fde_pkg::C_LOG)
    begin
      if (phys == `FDE_STATION_OFS)
      begin
        station_addr[7:0] <= rx.data;
      end
      if (phys == `FDE_STATION_OFS + 16'h0001)
      begin
        station_addr[15:8] <= rx.data;
      end
      if (phys == `FDE_ALIAS_EN_OFS)
      begin
        alias_en <= rx.data[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory stage: read data arrives one cycle after the address.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_valid <= 1'b0;
      s1_sof <= 1'b0;
      s1_din <= 8'h00;
      s1_byte <= 8'h00;
      s1_rd <= 1'b0;
      s1_wr <= 1'b0;
      s1_mask <= 8'hFF;
      s1_bc <= 1'b0;
      s1_log <= 1'b0;
      s1_idx <= '0;
    end
    else
    begin
      s1_valid <= rx_valid;
      s1_sof <= rx.sof;
      s1_din <= rx.data;
      s1_byte <= next_byte;
      s1_rd <= do_rd;
      s1_wr <= do_wr;
      s1_mask <= mask;
      s1_bc <= cls == fde_pkg::C_BC;
      s1_log <= cls == fde_pkg::C_LOG;
      s1_idx <= idx;
    end
  end

  fde_mem u_mem (
    .clk(clk),
    .arst_n(arst_n),
    .rd_addr(idx),
    .rd_data(rdata),
    .wr_en(s1_valid && s1_wr),
    .wr_addr(s1_idx),
    .wr_data(wr_byte)
  );

  always_comb
  begin
    out_byte = s1_byte;
    if (s1_rd)
    begin
      if (s1_bc)
      begin
        out_byte = s1_din | rdata;
      end
      else if (s1_log)
      begin
        out_byte = (rdata & s1_mask) | (s1_din & ~s1_mask);
      end
      else
      begin
        out_byte = rdata;
      end
    end
  end

  // Read data was fetched before this write lands.
  assign wr_byte = (s1_din & s1_mask) | (rdata & ~s1_mask);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_valid <= 1'b0;
      tx <= '0;
    end
    else
    begin
      tx_valid <= s1_valid;
      tx.sof <= s1_sof;
      tx.data <= out_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_tx_latency: assert property (rx_valid |-> ##2 tx_valid)
    else $error("Byte not forwarded two cycles later.");
  chk_sof_delay: assert property (rx_valid |-> ##2 tx.sof == $past(rx.sof, 2))
    else $error("Start marker not forwarded in place.");
  chk_index_kept: assert property ((rx_valid && is_hdr && !rx.sof
    && hdr_cnt == `FDE_HDR_IDX) |-> ##2 tx.data == $past(rx.data, 2))
    else $error("Index byte modified.");
  chk_position_inc: assert property ((rx_valid && is_hdr && !rx.sof
    && hdr_cnt == `FDE_HDR_ADDR0 && (cls == fde_pkg::C_POS || cls == fde_pkg::C_BC))
    |-> ##2 tx.data == $past(rx.data, 2) + 8'h01)
    else $error("Position low byte not incremented.");
  chk_reserved_pass: assert property ((rx_valid && !rx.sof && field != fde_pkg::F_IDLE
    && cls == fde_pkg::C_NONE && hdr_cnt != 4'h0) |-> ##2 tx.data == $past(rx.data, 2))
    else $error("Reserved command datagram altered.");
  chk_wkc_fail: assert property ((rx_valid && !rx.sof && field == fde_pkg::F_WKC0
    && !rd_ok && !wr_ok) |-> ##2 tx.data == $past(rx.data, 2))
    else $error("Working counter changed without success.");
  chk_wkc_both: assert property ((rx_valid && !rx.sof && field == fde_pkg::F_WKC0
    && is_rw && rd_ok && wr_ok) |-> ##2 tx.data == $past(rx.data, 2) + 8'h03)
    else $error("Readwrite success did not add three.");
  chk_station_cause: assert property ($changed(station_addr) |-> $past(do_wr))
    else $error("Station address changed without a datagram write.");
  chk_bcast_or: assert property ((s1_valid && s1_rd && s1_bc)
    |=> tx.data == ($past(s1_din) | $past(rdata)))
    else $error("Broadcast read did not merge with OR.");
  chk_unaddr_pass: assert property ((rx_valid && !rx.sof && field == fde_pkg::F_DATA
    && !do_rd) |-> ##2 tx.data == $past(rx.data, 2))
    else $error("Data changed without a read.");
  chk_last_stop: assert property ((rx_valid && !rx.sof && field == fde_pkg::F_WKC1
    && !more) |=> field == fde_pkg::F_IDLE)
    else $error("Decoding continued after last datagram.");

  cov_rmw_write: cover property (rx_valid && is_rmw && do_wr);
  cov_log_read: cover property (rx_valid && cls == fde_pkg::C_LOG && do_rd);
  cov_chained: cover property (rx_valid && field == fde_pkg::F_WKC1 && more);
endmodule : fde_executor
`default_nettype wire

/* File: verification/fde_master.sv */
// Network master model: sends datagrams into the executor and collects what comes out.
`timescale 1ns/1ps
`default_nettype none
module fde_master (
  input wire logic clk,
  output logic rx_valid,
  output fde_pkg::fde_byte_type rx,
  input wire logic tx_valid,
  input wire fde_pkg::fde_byte_type tx
);
  logic [7:0] got[$];
  logic got_sof[$];
  initial
  begin
    rx_valid = 1'b0;
    rx = '0;
  end
  always @(posedge clk)
  begin
    if (tx_valid)
    begin
      got.push_back(tx.data);
      got_sof.push_back(tx.sof);
    end
  end
  task put(input logic s, input logic [7:0] b);
    @(posedge clk);
    #1;
    rx_valid = 1'b1;
    rx.sof = s;
    rx.data = b;
  endtask : put
  // After a datagram each idle cycle inverts the byte on the line, so stale data never looks valid.
  task idle();
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx.sof = 1'b0;
    rx.data = ~rx.data;
  endtask : idle
  // The caller places a negative position for the target, so the increments reach zero there.
  task send(input logic [7:0] cmd, input logic [31:0] addr, input logic more, input logic first,
            input logic [15:0] d, input logic [15:0] working_counter);
    logic [7:0] b[14];
    b = '{cmd, 8'h5a, addr[7:0], addr[15:8], addr[23:16], addr[31:24], 8'h02, {more, 7'h00},
          8'h00, 8'h00, d[7:0], d[15:8], working_counter[7:0], working_counter[15:8]};
    for (int i = 0; i < 14; i++)
    begin
      put(first && (i == 0), b[i]);
    end
  endtask : send
endmodule : fde_master
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench of the datagram executor, driven through the network master model.
`timescale 1ns/1ps
`default_nettype none
`include "fde_cfg.svh"
`define FDE_CHECK(act, exp) \
  begin \
    comparisons++; \
    if ((act) !== (exp)) \
    begin \
      num_errors++; \
      $display("ERROR at %0t ns: got %h expected %h", $time, (act), (exp)); \
    end \
  end
module tb_top;
  logic clk;
  logic arst_n;
  logic rx_valid;
  fde_pkg::fde_byte_type rx;
  logic [15:0] alias_addr;
  fde_pkg::fde_lmu_type lmu;
  logic tx_valid;
  fde_pkg::fde_byte_type tx;
  logic [15:0] station_addr;
  logic alias_en;
  logic [7:0] res[14];
  int num_errors;
  int comparisons;
  fde_executor fde_executor_inst (.clk(clk), .arst_n(arst_n), .rx_valid(rx_valid), .rx(rx),
    .alias_addr(alias_addr), .lmu(lmu), .tx_valid(tx_valid), .tx(tx),
    .station_addr(station_addr), .alias_en(alias_en));
  fde_master fde_master_inst (.clk(clk), .rx_valid(rx_valid), .rx(rx), .tx_valid(tx_valid),
    .tx(tx));
  initial
  begin
    clk = 1'b0;
    forever
    begin
      #10 clk = ~clk;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task dg(input logic [7:0] cmd, input logic [31:0] addr, input logic [15:0] d,
          input logic [15:0] working_counter);
    fde_master_inst.got.delete();
    fde_master_inst.got_sof.delete();
    fde_master_inst.send(cmd, addr, 1'b0, 1'b1, d, working_counter);
    repeat (4) fde_master_inst.idle();
    `FDE_CHECK(fde_master_inst.got.size(), 14)
    for (int i = 0; i < 14; i++)
    begin
      res[i] = fde_master_inst.got[i];
    end
    `FDE_CHECK(res[0], cmd)
    `FDE_CHECK(res[1], 8'h5a)
    `FDE_CHECK({fde_master_inst.got_sof[0], fde_master_inst.got_sof[1]}, 2'b10)
  endtask : dg
  // The master judges each datagram by its returned address, data and working counter.
  task chk(input logic [31:0] addr, input logic [15:0] d, input logic [15:0] working_counter);
    `FDE_CHECK({res[5], res[4], res[3], res[2]}, addr)
    `FDE_CHECK({res[11], res[10]}, d)
    `FDE_CHECK({res[13], res[12]}, working_counter)
  endtask : chk
  ////////////////////////////////////////////////////////////////////////////////
  // Position addressing opens with this start-up style scan of one slave.
  task t_position();
    dg(`FDE_CMD_POS_WR, 32'h1000_0000, 16'hbeef, 16'h0005);
    chk(32'h1000_0001, 16'hbeef, 16'h0006);
    dg(`FDE_CMD_POS_RD, 32'h1000_ffff, 16'h0033, 16'h00ff);
    chk(32'h1000_0000, 16'h0033, 16'h00ff);
    dg(`FDE_CMD_POS_RD, 32'h1000_0000, 16'h0033, 16'h00ff);
    chk(32'h1000_0001, 16'hbeef, 16'h0100);
  endtask : t_position
  task t_node();
    dg(`FDE_CMD_BC_WR, 32'h0010_fffe, 16'h1234, 16'h0000);
    chk(32'h0010_ffff, 16'h1234, 16'h0001);
    `FDE_CHECK(station_addr, 16'h1234)
    dg(`FDE_CMD_NODE_RD, 32'h1000_1234, 16'h0000, 16'h0000);
    chk(32'h1000_1234, 16'hbeef, 16'h0001);
    dg(`FDE_CMD_NODE_RD, 32'h1000_0777, 16'h0000, 16'h0000);
    chk(32'h1000_0777, 16'h0000, 16'h0000);
    // The master enables alias matching before using it.
    dg(`FDE_CMD_BC_WR, 32'h0012_0000, 16'h0001, 16'h0000);
    `FDE_CHECK(alias_en, 1'b1)
    dg(`FDE_CMD_NODE_RD, 32'h1000_0777, 16'h0000, 16'h0000);
    chk(32'h1000_0777, 16'hbeef, 16'h0001);
    // The local application moves its alias; the station address must not follow.
    alias_addr = 16'h0888;
    dg(`FDE_CMD_NODE_RD, 32'h1000_0888, 16'h0000, 16'h0000);
    chk(32'h1000_0888, 16'hbeef, 16'h0001);
    `FDE_CHECK(station_addr, 16'h1234)
  endtask : t_node
  task t_readwrite();
    dg(`FDE_CMD_NODE_RW, 32'h1000_1234, 16'h1357, 16'h0000);
    chk(32'h1000_1234, 16'hbeef, 16'h0003);
    dg(`FDE_CMD_POS_RW, 32'h1000_0000, 16'h2468, 16'h0010);
    chk(32'h1000_0001, 16'h1357, 16'h0013);
  endtask : t_readwrite
  task t_broadcast();
    dg(`FDE_CMD_BC_RD, 32'h1000_0005, 16'h00f0, 16'h0000);
    chk(32'h1000_0006, 16'h24f8, 16'h0001);
    dg(`FDE_CMD_BC_RW, 32'h1000_0000, 16'h8000, 16'h0000);
    chk(32'h1000_0001, 16'ha468, 16'h0003);
  endtask : t_broadcast
  task t_access();
    dg(`FDE_CMD_POS_WR, 32'h2000_0000, 16'h1111, 16'h0007);
    chk(32'h2000_0001, 16'h1111, 16'h0007);
    dg(`FDE_CMD_NODE_RD, 32'h2000_1234, 16'h2222, 16'h0000);
    chk(32'h2000_1234, 16'h2222, 16'h0000);
    dg(`FDE_CMD_NODE_WR, 32'h0020_1234, 16'h4242, 16'h0000);
    chk(32'h0020_1234, 16'h4242, 16'h0001);
    dg(`FDE_CMD_POS_RD, 32'h0020_0000, 16'h0000, 16'h0000);
    chk(32'h0020_0001, 16'h4242, 16'h0001);
  endtask : t_access
  task t_multi();
    dg(`FDE_CMD_POS_RMW, 32'h1000_ffff, 16'h6666, 16'h0000);
    chk(32'h1000_0000, 16'h6666, 16'h0001);
    dg(`FDE_CMD_POS_RMW, 32'h1000_0000, 16'h0000, 16'h0000);
    chk(32'h1000_0001, 16'h6666, 16'h0001);
    dg(`FDE_CMD_NODE_RMW, 32'h1000_4321, 16'h6767, 16'h0000);
    chk(32'h1000_4321, 16'h6767, 16'h0001);
    dg(`FDE_CMD_NODE_RMW, 32'h1000_1234, 16'h0000, 16'h0000);
    chk(32'h1000_1234, 16'h6767, 16'h0001);
  endtask : t_multi
  task t_reserved();
    logic [7:0] codes[3];
    codes = '{`FDE_CMD_NOP, 8'h0f, 8'hff};
    for (int i = 0; i < 3; i++)
    begin
      dg(codes[i], 32'h1000_0000, 16'h5555, 16'h0009);
      chk(32'h1000_0000, 16'h5555, 16'h0009);
    end
    dg(`FDE_CMD_POS_RD, 32'h1000_0000, 16'h0000, 16'h0000);
    chk(32'h1000_0001, 16'h6767, 16'h0001);
  endtask : t_reserved
  task t_logical();
    // The mapping unit is configured before any logical command is sent.
    lmu = '{1'b1, 1'b1, 1'b1, 32'h0001_0000, 16'h0001, 16'h1004, 3'd0, 3'd3};
    dg(`FDE_CMD_NODE_WR, 32'h1004_1234, 16'h0055, 16'h0000);
    dg(`FDE_CMD_LOG_RD, 32'h0001_0000, 16'hcca0, 16'h0000);
    chk(32'h0001_0000, 16'hcca5, 16'h0001);
    dg(`FDE_CMD_LOG_WR, 32'h0001_0000, 16'h00ff, 16'h0000);
    chk(32'h0001_0000, 16'h00ff, 16'h0001);
    dg(`FDE_CMD_NODE_RD, 32'h1004_1234, 16'h0000, 16'h0000);
    chk(32'h1004_1234, 16'h005f, 16'h0001);
    lmu.rd_en = 1'b0;
    dg(`FDE_CMD_LOG_RW, 32'h0001_0000, 16'h0000, 16'h0000);
    chk(32'h0001_0000, 16'h0000, 16'h0002);
    dg(`FDE_CMD_NODE_RD, 32'h1004_1234, 16'h0000, 16'h0000);
    chk(32'h1004_1234, 16'h0050, 16'h0001);
    lmu.rd_en = 1'b1;
    dg(`FDE_CMD_LOG_RD, 32'h0002_0000, 16'h0000, 16'h0000);
    chk(32'h0002_0000, 16'h0000, 16'h0000);
  endtask : t_logical
  task t_chain();
    fde_master_inst.got.delete();
    fde_master_inst.got_sof.delete();
    fde_master_inst.send(`FDE_CMD_NODE_WR, 32'h1000_1234, 1'b1, 1'b1, 16'h7777, 16'h0000);
    fde_master_inst.send(`FDE_CMD_POS_RD, 32'h1000_0000, 1'b0, 1'b0, 16'h0000, 16'h0000);
    repeat (4) fde_master_inst.idle();
    `FDE_CHECK(fde_master_inst.got.size(), 28)
    `FDE_CHECK(fde_master_inst.got[12], 8'h01)
    `FDE_CHECK(fde_master_inst.got[15], 8'h5a)
    `FDE_CHECK({fde_master_inst.got[25], fde_master_inst.got[24]}, 16'h7777)
    `FDE_CHECK(fde_master_inst.got[26], 8'h01)
    `FDE_CHECK({fde_master_inst.got_sof[0], fde_master_inst.got_sof[14]}, 2'b10)
  endtask : t_chain
  ////////////////////////////////////////////////////////////////////////////////
  task conclude();
    $display("Comparisons: %0d, mismatches: %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
    begin
      $display("== PASSED ==");
    end
    else
    begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  initial
  begin
    #100_000;
    num_errors++;
    conclude();
  end
  initial
  begin
    num_errors = 0;
    comparisons = 0;
    arst_n = 1'b0;
    alias_addr = 16'h0777;
    lmu = '0;
    repeat (3) @(posedge clk);
    #1;
    `FDE_CHECK(station_addr, 16'h0000)
    `FDE_CHECK(alias_en, 1'b0)
    arst_n = 1'b1;
    t_position();
    t_node();
    t_readwrite();
    t_broadcast();
    t_access();
    t_multi();
    t_reserved();
    t_logical();
    t_chain();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
